// *** core/idec_decoder.sv ***
// How it works
// - Each instruction is one 16-bit word; opcode bits pick the operand format.
// - Single-destination format: bits 11..8 name a direct, indirect or pre-decrement destination.
// - Single-source format: bits 11..8 name a source, possibly program-counter relative.
// - Single-source register may be a post-increment pointer or a jump target.
// - Two-register format: destination in bits 11..8, source in bits 7..4.
// - Multiply-accumulate decodes both fields as post-increment sources into accumulators.
// - Two-register stores allow register-zero indexed, indirect and pre-decrement; loads allow post-increment.
// - Short-displacement formats: base in bits 7..4, displacement 3..0, register zero implied.
// - Register-pair displacement: destination, source and displacement in three nibbles.
// - Immediate-only format: 8-bit data; target register zero, global-base byte or none.
// - Logical test, and, or, exclusive-or immediates are zero-extended.
// - Data displacements are zero-extended and scaled by one, two or four.
// - Branch displacements are sign-extended and doubled.
`timescale 1ns/1ns
module idec_decoder (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic insn_valid,
	input wire logic [15:0] insn,
	output logic valid_reg,
	output idec_pkg::idec_fmt_t fmt_reg,
	output logic [3:0] dst_num_reg,
	output logic [3:0] src_num_reg,
	output idec_pkg::idec_mode_t dst_mode_reg,
	output idec_pkg::idec_mode_t src_mode_reg,
	output logic [1:0] size_reg,
	output logic [31:0] imm_value_reg,
	output logic [31:0] disp_value_reg,
	output logic mac_reg,
	output logic illegal_reg
);

	// Zero-extend a displacement and scale it by the access size.
	function automatic logic [31:0] idec_scale(input logic [7:0] d, input logic [1:0] sz);
		idec_scale = {24'h0, d} << sz;
	endfunction : idec_scale

	// Sign-extend a branch displacement (8 or 12 bits) and double it.
	function automatic logic [31:0] idec_branch(input logic [11:0] d, input logic wide);
		logic [31:0] s;
		s = wide ? {{20{d[11]}}, d} : {{24{d[7]}}, d[7:0]};
		idec_branch = s << 1;
	endfunction : idec_branch

	logic [3:0] op;
	logic [3:0] nf;
	logic [3:0] mf;
	logic [3:0] lo;
	logic [7:0] lbyte;
	idec_pkg::idec_fmt_t fmt_next;
	idec_pkg::idec_mode_t dst_mode_next;
	idec_pkg::idec_mode_t src_mode_next;
	logic [3:0] dst_num_next;
	logic [3:0] src_num_next;
	logic [1:0] size_next;
	logic [31:0] imm_value_next;
	logic [31:0] disp_value_next;
	logic mac_next;
	logic illegal_next;

	// Split the word into its four nibbles once.
	assign op = insn[idec_pkg::OP_HI:idec_pkg::OP_LO];
	assign nf = insn[idec_pkg::NF_HI:idec_pkg::NF_LO];
	assign mf = insn[idec_pkg::MF_HI:idec_pkg::MF_LO];
	assign lo = insn[idec_pkg::LO_HI:idec_pkg::LO_LO];
	assign lbyte = insn[idec_pkg::MF_HI:idec_pkg::LO_LO];

	// Classify the word; every path starts from the zero-operand defaults.
	always_comb begin
		fmt_next = idec_pkg::FMT_ZERO;
		dst_mode_next = idec_pkg::MODE_NONE;
		src_mode_next = idec_pkg::MODE_NONE;
		dst_num_next = nf;
		src_num_next = mf;
		size_next = lo[1:0];
		imm_value_next = idec_pkg::VAL_RST;
		disp_value_next = idec_pkg::VAL_RST;
		mac_next = 1'b0;
		illegal_next = 1'b0;
		case (op)
			4'h0: begin
				if (lo == 4'h2 || lo == 4'ha || (lo == 4'h9 && mf == 4'h2)) begin
					fmt_next = idec_pkg::FMT_N;
					dst_mode_next = idec_pkg::MODE_DIRECT;
					src_mode_next = (lo == 4'h9) ? idec_pkg::MODE_NONE : idec_pkg::MODE_CTRL;
				end else if (lo == 4'h3) begin
					fmt_next = idec_pkg::FMT_M;
					src_num_next = nf;
					src_mode_next = idec_pkg::MODE_PC_REL;
				end else if (lo == 4'h4 || lo == 4'h5 || lo == 4'h6) begin
					fmt_next = idec_pkg::FMT_NM;
					src_mode_next = idec_pkg::MODE_DIRECT;
					dst_mode_next = idec_pkg::MODE_IDX_ZERO;
				end else if (lo == 4'hc || lo == 4'hd || lo == 4'he) begin
					fmt_next = idec_pkg::FMT_NM;
					src_mode_next = idec_pkg::MODE_IDX_ZERO;
					dst_mode_next = idec_pkg::MODE_DIRECT;
				end else if (lo == 4'h7) begin
					fmt_next = idec_pkg::FMT_NM;
					src_mode_next = idec_pkg::MODE_DIRECT;
					dst_mode_next = idec_pkg::MODE_ACC;
				end else if (lo == 4'hf) begin
					fmt_next = idec_pkg::FMT_NM;
					src_mode_next = idec_pkg::MODE_POSTINC;
					dst_mode_next = idec_pkg::MODE_POSTINC;
					mac_next = 1'b1;
				end else if (lo == 4'h0 || lo == 4'h1) begin
					illegal_next = 1'b1;
				end
			end
			4'h1: begin
				fmt_next = idec_pkg::FMT_NMD;
				src_mode_next = idec_pkg::MODE_DIRECT;
				dst_mode_next = idec_pkg::MODE_DISP_REG;
				size_next = idec_pkg::SZ_LONG;
				disp_value_next = idec_scale({4'h0, lo}, idec_pkg::SZ_LONG);
			end
			4'h2, 4'h3, 4'h6: begin
				fmt_next = idec_pkg::FMT_NM;
				src_mode_next = idec_pkg::MODE_DIRECT;
				dst_mode_next = idec_pkg::MODE_DIRECT;
				if (op == 4'h2 && lo[3:2] == 2'h0) begin
					dst_mode_next = idec_pkg::MODE_INDIRECT;
				end else if (op == 4'h2 && lo[3:2] == 2'h1 && lo != 4'h7) begin
					dst_mode_next = idec_pkg::MODE_PREDEC;
				end else if (op == 4'h6 && lo[3:2] == 2'h0 && lo != 4'h3) begin
					src_mode_next = idec_pkg::MODE_INDIRECT;
				end else if (op == 4'h6 && lo[3:2] == 2'h1 && lo != 4'h7) begin
					src_mode_next = idec_pkg::MODE_POSTINC;
				end
			end
			4'h4: begin
				if (lo == 4'hf) begin
					fmt_next = idec_pkg::FMT_NM;
					src_mode_next = idec_pkg::MODE_POSTINC;
					dst_mode_next = idec_pkg::MODE_POSTINC;
					mac_next = 1'b1;
				end else if (lo == 4'h6 || lo == 4'h7 || lo == 4'ha || lo == 4'he
						|| lbyte == 8'h0b || lbyte == 8'h2b) begin
					fmt_next = idec_pkg::FMT_M;
					src_num_next = nf;
					src_mode_next = (lo == 4'h6 || lo == 4'h7) ? idec_pkg::MODE_POSTINC
						: (lo == 4'hb) ? idec_pkg::MODE_INDIRECT : idec_pkg::MODE_DIRECT;
					dst_mode_next = (lo == 4'hb) ? idec_pkg::MODE_NONE : idec_pkg::MODE_CTRL;
				end else begin
					fmt_next = idec_pkg::FMT_N;
					src_mode_next = (lo == 4'h2 || lo == 4'h3) ? idec_pkg::MODE_CTRL
						: idec_pkg::MODE_NONE;
					dst_mode_next = (lo == 4'h2 || lo == 4'h3) ? idec_pkg::MODE_PREDEC
						: (lbyte == 8'h1b) ? idec_pkg::MODE_INDIRECT : idec_pkg::MODE_DIRECT;
				end
			end
			4'h5: begin
				fmt_next = idec_pkg::FMT_NMD;
				src_mode_next = idec_pkg::MODE_DISP_REG;
				dst_mode_next = idec_pkg::MODE_DIRECT;
				size_next = idec_pkg::SZ_LONG;
				disp_value_next = idec_scale({4'h0, lo}, idec_pkg::SZ_LONG);
			end
			4'h7, 4'he: begin
				fmt_next = idec_pkg::FMT_NI;
				src_mode_next = idec_pkg::MODE_IMM;
				dst_mode_next = idec_pkg::MODE_DIRECT;
				imm_value_next = {{24{lbyte[7]}}, lbyte};
			end
			4'h8: begin
				size_next = nf[1:0];
				if (nf == 4'h0 || nf == 4'h1) begin
					fmt_next = idec_pkg::FMT_ND4;
					dst_num_next = mf;
					src_num_next = idec_pkg::GR_ZERO;
					dst_mode_next = idec_pkg::MODE_DISP_REG;
					src_mode_next = idec_pkg::MODE_ZERO_REG;
					disp_value_next = idec_scale({4'h0, lo}, nf[1:0]);
				end else if (nf == 4'h4 || nf == 4'h5) begin
					fmt_next = idec_pkg::FMT_MD;
					dst_num_next = idec_pkg::GR_ZERO;
					dst_mode_next = idec_pkg::MODE_ZERO_REG;
					src_mode_next = idec_pkg::MODE_DISP_REG;
					disp_value_next = idec_scale({4'h0, lo}, nf[1:0]);
				end else if (nf == 4'h8) begin
					fmt_next = idec_pkg::FMT_I;
					dst_num_next = idec_pkg::GR_ZERO;
					dst_mode_next = idec_pkg::MODE_ZERO_REG;
					src_mode_next = idec_pkg::MODE_IMM;
					imm_value_next = {{24{lbyte[7]}}, lbyte};
				end else if (nf[0]) begin
					fmt_next = idec_pkg::FMT_D;
					src_mode_next = idec_pkg::MODE_PC_REL;
					disp_value_next = idec_branch({4'h0, lbyte}, 1'b0);
				end else begin
					illegal_next = 1'b1;
				end
			end
			4'h9, 4'hd: begin
				fmt_next = idec_pkg::FMT_ND8;
				src_mode_next = idec_pkg::MODE_PC_REL;
				dst_mode_next = idec_pkg::MODE_DIRECT;
				size_next = op[2] ? idec_pkg::SZ_LONG : idec_pkg::SZ_WORD;
				disp_value_next = idec_scale(lbyte, size_next);
			end
			4'ha, 4'hb: begin
				fmt_next = idec_pkg::FMT_D12;
				src_mode_next = idec_pkg::MODE_PC_REL;
				disp_value_next = idec_branch(insn[11:0], 1'b1);
			end
			4'hc: begin
				size_next = nf[1:0];
				if (nf == 4'h3) begin
					fmt_next = idec_pkg::FMT_I;
					src_mode_next = idec_pkg::MODE_IMM;
					imm_value_next = {22'h0, lbyte, 2'h0};
				end else if (nf[3]) begin
					fmt_next = idec_pkg::FMT_I;
					src_mode_next = idec_pkg::MODE_IMM;
					dst_num_next = idec_pkg::GR_ZERO;
					dst_mode_next = nf[2] ? idec_pkg::MODE_IDX_GBASE : idec_pkg::MODE_ZERO_REG;
					imm_value_next = {24'h0, lbyte};
				end else begin
					fmt_next = idec_pkg::FMT_D;
					dst_num_next = idec_pkg::GR_ZERO;
					src_num_next = idec_pkg::GR_ZERO;
					if (nf == 4'h7) begin
						size_next = idec_pkg::SZ_LONG;
						src_mode_next = idec_pkg::MODE_PC_REL;
						dst_mode_next = idec_pkg::MODE_ZERO_REG;
					end else if (nf[2]) begin
						src_mode_next = idec_pkg::MODE_DISP_GBASE;
						dst_mode_next = idec_pkg::MODE_ZERO_REG;
					end else begin
						src_mode_next = idec_pkg::MODE_ZERO_REG;
						dst_mode_next = idec_pkg::MODE_DISP_GBASE;
					end
					disp_value_next = idec_scale(lbyte, size_next);
				end
			end
			default: begin
				illegal_next = 1'b1;
			end
		endcase
	end

	// Valid follows the fetch strobe with one cycle of latency.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= insn_valid;
		end
	end

	// Decoded fields are captured every cycle so outputs come straight from flops.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fmt_reg <= idec_pkg::FMT_ZERO;
			dst_num_reg <= idec_pkg::NUM_RST;
			src_num_reg <= idec_pkg::NUM_RST;
			dst_mode_reg <= idec_pkg::MODE_NONE;
			src_mode_reg <= idec_pkg::MODE_NONE;
			size_reg <= idec_pkg::SZ_BYTE;
			imm_value_reg <= idec_pkg::VAL_RST;
			disp_value_reg <= idec_pkg::VAL_RST;
			mac_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			fmt_reg <= fmt_next;
			dst_num_reg <= dst_num_next;
			src_num_reg <= src_num_next;
			dst_mode_reg <= dst_mode_next;
			src_mode_reg <= src_mode_next;
			size_reg <= size_next;
			imm_value_reg <= imm_value_next;
			disp_value_reg <= disp_value_next;
			mac_reg <= mac_next;
			illegal_reg <= illegal_next;
		end
	end

	// Copy of the previous word, read only by the checks below.
	logic [15:0] insn_q;
	always_ff @(posedge clk_sys) begin
		insn_q <= insn;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_nop_zero_fmt: assert property (insn == 16'h0009 |=> fmt_reg == idec_pkg::FMT_ZERO)
		else $error("zero-operand word not decoded as zero format");
	a_single_dst: assert property (insn[15:12] == 4'h0 && insn[3:0] == 4'ha
			|=> fmt_reg == idec_pkg::FMT_N && dst_num_reg == insn_q[11:8])
		else $error("single destination field wrong");
	a_rel_branch_src: assert property (insn[15:12] == 4'h0 && insn[3:0] == 4'h3
			|=> src_num_reg == insn_q[11:8] && src_mode_reg == idec_pkg::MODE_PC_REL)
		else $error("register relative branch source wrong");
	a_ctrl_postinc: assert property (insn[15:12] == 4'h4 && insn[3:0] == 4'h7
			|=> src_mode_reg == idec_pkg::MODE_POSTINC && dst_mode_reg == idec_pkg::MODE_CTRL)
		else $error("control load pointer mode wrong");
	a_pair_fields: assert property (insn[15:12] == 4'h3 |=> fmt_reg == idec_pkg::FMT_NM
			&& dst_num_reg == insn_q[11:8] && src_num_reg == insn_q[7:4])
		else $error("register pair fields wrong");
	a_mac_sources: assert property (mac_reg |-> src_mode_reg == idec_pkg::MODE_POSTINC
			&& dst_mode_reg == idec_pkg::MODE_POSTINC && insn_q[3:0] == 4'hf)
		else $error("accumulate operands wrong");
	a_indexed_store: assert property (insn[15:12] == 4'h0 && insn[3:0] == 4'h6
			|=> dst_mode_reg == idec_pkg::MODE_IDX_ZERO && size_reg == idec_pkg::SZ_LONG)
		else $error("indexed store decode wrong");
	a_short_disp: assert property (insn[15:8] == 8'h81 |=> src_num_reg == idec_pkg::GR_ZERO
			&& dst_num_reg == insn_q[7:4] && disp_value_reg == {27'h0, insn_q[3:0], 1'b0})
		else $error("short displacement decode wrong");
	a_pair_disp: assert property (insn[15:12] == 4'h5 |=> fmt_reg == idec_pkg::FMT_NMD
			&& disp_value_reg == {26'h0, insn_q[3:0], 2'h0})
		else $error("register pair displacement wrong");
	a_trap_imm: assert property (insn[15:8] == 8'hc3 |=> dst_mode_reg == idec_pkg::MODE_NONE
			&& imm_value_reg == {22'h0, insn_q[7:0], 2'h0})
		else $error("trap immediate wrong");
	a_logic_zext: assert property (insn[15:8] == 8'hca
			|=> imm_value_reg == {24'h0, insn_q[7:0]})
		else $error("logical immediate not zero-extended");
	a_long_branch: assert property (insn[15:12] == 4'ha
			|=> disp_value_reg == {{19{insn_q[11]}}, insn_q[11:0], 1'b0})
		else $error("long branch displacement wrong");

	c_mac: cover property (insn_valid && insn[15:12] == 4'h4 && insn[3:0] == 4'hf ##1 mac_reg);
	c_long_branch: cover property (insn_valid && insn[15:12] == 4'hb ##1 valid_reg);
	c_trap: cover property (insn_valid && insn[15:8] == 8'hc3 ##1 valid_reg);

endmodule : idec_decoder

// *** core/idec_pkg.sv ***
package idec_pkg;

	// Instruction field positions within the 16-bit word.
	localparam int WORD_W = 16;
	localparam int OP_HI = 15;
	localparam int OP_LO = 12;
	localparam int NF_HI = 11;
	localparam int NF_LO = 8;
	localparam int MF_HI = 7;
	localparam int MF_LO = 4;
	localparam int LO_HI = 3;
	localparam int LO_LO = 0;

	// General register zero, implied by several formats.
	localparam logic [3:0] GR_ZERO = 4'h0;

	// Access sizes, used as the displacement shift count.
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// Reset values of the decoded outputs.
	localparam logic [3:0] NUM_RST = 4'h0;
	localparam logic [31:0] VAL_RST = 32'h0;

	// Operand formats, one-hot.
	typedef enum logic [11:0] {
		FMT_ZERO = 12'h001,
		FMT_N = 12'h002,
		FMT_M = 12'h004,
		FMT_NM = 12'h008,
		FMT_MD = 12'h010,
		FMT_ND4 = 12'h020,
		FMT_NMD = 12'h040,
		FMT_D = 12'h080,
		FMT_D12 = 12'h100,
		FMT_ND8 = 12'h200,
		FMT_I = 12'h400,
		FMT_NI = 12'h800
	} idec_fmt_t;

	// Operand addressing classes, one-hot.
	typedef enum logic [13:0] {
		MODE_NONE = 14'h0001,
		MODE_DIRECT = 14'h0002,
		MODE_INDIRECT = 14'h0004,
		MODE_POSTINC = 14'h0008,
		MODE_PREDEC = 14'h0010,
		MODE_IDX_ZERO = 14'h0020,
		MODE_DISP_REG = 14'h0040,
		MODE_DISP_GBASE = 14'h0080,
		MODE_IDX_GBASE = 14'h0100,
		MODE_PC_REL = 14'h0200,
		MODE_IMM = 14'h0400,
		MODE_ZERO_REG = 14'h0800,
		MODE_CTRL = 14'h1000,
		MODE_ACC = 14'h2000
	} idec_mode_t;

endpackage : idec_pkg

// *** verif/idec_fetch_model.sv ***
`timescale 1ns/1ns
// Behavioural fetch stage that hands the decoder one whole word per call.
module idec_fetch_model (
	output logic insn_valid,
	output logic [15:0] insn
);
	// Both lines start defined so that the first sampled word is never unknown.
	initial begin
		insn_valid = 1'b0;
		insn = 16'h0009;
	end

	// A word always travels as all sixteen bits together with its valid flag.
	task automatic put(input logic [15:0] w);
		insn_valid = 1'b1;
		insn = w;
	endtask : put

	// Between words the bus shows the inverted last word, so stale data cannot pass by chance.
	task automatic idle();
		insn_valid = 1'b0;
		insn = ~insn;
	endtask : idle
endmodule : idec_fetch_model

// *** verif/instruction_format_decoder_tb.sv ***
`timescale 1ns/1ns
module instruction_format_decoder_tb;
	logic clk_sys;
	logic rst;
	logic insn_valid;
	logic [15:0] insn;
	logic valid_reg;
	idec_pkg::idec_fmt_t fmt_reg;
	logic [3:0] dst_num_reg;
	logic [3:0] src_num_reg;
	idec_pkg::idec_mode_t dst_mode_reg;
	idec_pkg::idec_mode_t src_mode_reg;
	logic [1:0] size_reg;
	logic [31:0] imm_value_reg;
	logic [31:0] disp_value_reg;
	logic mac_reg;
	logic illegal_reg;
	int err_count;
	int tests_run;

	idec_fetch_model fetch (.insn_valid(insn_valid), .insn(insn));

	idec_decoder dut (.clk_sys(clk_sys), .rst(rst), .insn_valid(insn_valid), .insn(insn),
		.valid_reg(valid_reg), .fmt_reg(fmt_reg), .dst_num_reg(dst_num_reg),
		.src_num_reg(src_num_reg), .dst_mode_reg(dst_mode_reg), .src_mode_reg(src_mode_reg),
		.size_reg(size_reg), .imm_value_reg(imm_value_reg), .disp_value_reg(disp_value_reg),
		.mac_reg(mac_reg), .illegal_reg(illegal_reg));

	// The 20 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Prints the counts and the verdict; the only place where the run ends.
	task automatic close_out();
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// Compares one field; four-state inequality so an unknown never matches.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Format and destination side of the current decode.
	task automatic dchk(input logic [11:0] f, input logic [3:0] n, input logic [13:0] m);
		chk("fmt", fmt_reg, f);
		chk("dst_num", dst_num_reg, n);
		chk("dst_mode", dst_mode_reg, m);
	endtask : dchk

	// Source side of the current decode.
	task automatic schk(input logic [3:0] n, input logic [13:0] m);
		chk("src_num", src_num_reg, n);
		chk("src_mode", src_mode_reg, m);
	endtask : schk

	// Presents a word just after an edge; on return its decode is settled, latency one.
	// Calls follow each other with no gap, so every scenario runs back to back.
	task automatic step(input logic [15:0] w);
		fetch.put(w);
		@(posedge clk_sys);
		#2;
	endtask : step

	// Walk example, then a cycle without valid whose word is garbage.
	task automatic t_walk();
		step(16'h3128);
		chk("valid", valid_reg, 1'b1);
		dchk(idec_pkg::FMT_NM, 4'h1, idec_pkg::MODE_DIRECT);
		schk(4'h2, idec_pkg::MODE_DIRECT);
		fetch.idle();
		@(posedge clk_sys);
		#2;
		chk("valid", valid_reg, 1'b0);
	endtask : t_walk

	// Single destination, direct and pre-decrement for a control register store.
	task automatic t_single_dst();
		step(16'h0129);
		dchk(idec_pkg::FMT_N, 4'h1, idec_pkg::MODE_DIRECT);
		step(16'h4303);
		dchk(idec_pkg::FMT_N, 4'h3, idec_pkg::MODE_PREDEC);
		chk("src_mode", src_mode_reg, idec_pkg::MODE_CTRL);
	endtask : t_single_dst

	// Single source: relative branch, jump target and post-increment control load.
	task automatic t_single_src();
		step(16'h0523);
		chk("fmt", fmt_reg, idec_pkg::FMT_M);
		schk(4'h5, idec_pkg::MODE_PC_REL);
		step(16'h462b);
		schk(4'h6, idec_pkg::MODE_INDIRECT);
		step(16'h4707);
		schk(4'h7, idec_pkg::MODE_POSTINC);
		chk("dst_mode", dst_mode_reg, idec_pkg::MODE_CTRL);
	endtask : t_single_src

	// Two-register stores and loads with indexed, pre-decrement and post-increment forms.
	task automatic t_two_reg();
		step(16'h0ab4);
		dchk(idec_pkg::FMT_NM, 4'ha, idec_pkg::MODE_IDX_ZERO);
		schk(4'hb, idec_pkg::MODE_DIRECT);
		step(16'h2346);
		dchk(idec_pkg::FMT_NM, 4'h3, idec_pkg::MODE_PREDEC);
		step(16'h6356);
		dchk(idec_pkg::FMT_NM, 4'h3, idec_pkg::MODE_DIRECT);
		schk(4'h5, idec_pkg::MODE_POSTINC);
	endtask : t_two_reg

	// Multiply-accumulate, followed at once by a plain add that must drop the flag.
	task automatic t_mac();
		step(16'h4e2f);
		chk("mac", mac_reg, 1'b1);
		dchk(idec_pkg::FMT_NM, 4'he, idec_pkg::MODE_POSTINC);
		schk(4'h2, idec_pkg::MODE_POSTINC);
		step(16'h3128);
		chk("mac", mac_reg, 1'b0);
		step(16'h0127);
		dchk(idec_pkg::FMT_NM, 4'h1, idec_pkg::MODE_ACC);
		schk(4'h2, idec_pkg::MODE_DIRECT);
		chk("mac", mac_reg, 1'b0);
	endtask : t_mac

	// Short and pair displacements at their largest nibble except the first (nibble 5), scaled per access size.
	task automatic t_disp();
		step(16'h8115);
		dchk(idec_pkg::FMT_ND4, 4'h1, idec_pkg::MODE_DISP_REG);
		schk(idec_pkg::GR_ZERO, idec_pkg::MODE_ZERO_REG);
		chk("disp", disp_value_reg, 32'h0000000a);
		chk("size", size_reg, idec_pkg::SZ_WORD);
		step(16'h84ef);
		schk(4'he, idec_pkg::MODE_DISP_REG);
		chk("dst_num", dst_num_reg, idec_pkg::GR_ZERO);
		chk("disp", disp_value_reg, 32'h0000000f);
		step(16'h123f);
		dchk(idec_pkg::FMT_NMD, 4'h2, idec_pkg::MODE_DISP_REG);
		schk(4'h3, idec_pkg::MODE_DIRECT);
		chk("disp", disp_value_reg, 32'h0000003c);
		step(16'h523f);
		dchk(idec_pkg::FMT_NMD, 4'h2, idec_pkg::MODE_DIRECT);
		schk(4'h3, idec_pkg::MODE_DISP_REG);
	endtask : t_disp

	// Branch displacements, both signs at 12 bits and negative only at 8 bits, and 8-bit data displacements.
	task automatic t_branch();
		step(16'ha801);
		chk("fmt", fmt_reg, idec_pkg::FMT_D12);
		chk("disp", disp_value_reg, 32'hfffff002);
		step(16'ha7ff);
		chk("disp", disp_value_reg, 32'h00000ffe);
		step(16'h89ff);
		chk("fmt", fmt_reg, idec_pkg::FMT_D);
		chk("disp", disp_value_reg, 32'hfffffffe);
		step(16'h93ff);
		dchk(idec_pkg::FMT_ND8, 4'h3, idec_pkg::MODE_DIRECT);
		step(16'hc6ff);
		chk("src_mode", src_mode_reg, idec_pkg::MODE_DISP_GBASE);
		chk("disp", disp_value_reg, 32'h000003fc);
	endtask : t_branch

	// Immediate forms: logical four, trap, global-base byte and register-plus-immediate.
	task automatic t_imm();
		logic [15:0] ops [4] = '{16'hc880, 16'hc980, 16'hca80, 16'hcb80};
		foreach (ops[i]) begin
			step(ops[i]);
			chk("fmt", fmt_reg, idec_pkg::FMT_I);
			chk("imm", imm_value_reg, 32'h00000080);
		end
		chk("dst_mode", dst_mode_reg, idec_pkg::MODE_ZERO_REG);
		step(16'hc3ff);
		chk("imm", imm_value_reg, 32'h000003fc);
		chk("dst_mode", dst_mode_reg, idec_pkg::MODE_NONE);
		step(16'hcd80);
		chk("dst_mode", dst_mode_reg, idec_pkg::MODE_IDX_GBASE);
		step(16'he780);
		dchk(idec_pkg::FMT_NI, 4'h7, idec_pkg::MODE_DIRECT);
		chk("imm", imm_value_reg, 32'hffffff80);
		step(16'he57f);
		chk("imm", imm_value_reg, 32'h0000007f);
	endtask : t_imm

	// Whole-word opcode and an unknown word, then a reset in mid-stream.
	task automatic t_zero();
		step(16'h0009);
		chk("fmt", fmt_reg, idec_pkg::FMT_ZERO);
		chk("illegal", illegal_reg, 1'b0);
		step(16'hf000);
		chk("illegal", illegal_reg, 1'b1);
		dchk(idec_pkg::FMT_ZERO, idec_pkg::NUM_RST, idec_pkg::MODE_NONE);
		rst = 1'b1;
		step(16'h3128);
		chk("valid", valid_reg, 1'b0);
		chk("fmt", fmt_reg, idec_pkg::FMT_ZERO);
		rst = 1'b0;
	endtask : t_zero

	// Cuts a hang short; no scenario should come near this bound.
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		close_out();
	end

	// Main sequence: reset for 16 cycles, check reset values, then the scenarios.
	initial begin
		err_count = 0;
		tests_run = 0;
		rst = 1'b1;
		repeat (16) @(posedge clk_sys);
		#2;
		dchk(idec_pkg::FMT_ZERO, idec_pkg::NUM_RST, idec_pkg::MODE_NONE);
		chk("imm", imm_value_reg, idec_pkg::VAL_RST);
		chk("disp", disp_value_reg, idec_pkg::VAL_RST);
		rst = 1'b0;
		t_walk();
		t_single_dst();
		t_single_src();
		t_two_reg();
		t_mac();
		t_disp();
		t_branch();
		t_imm();
		t_zero();
		close_out();
	end
endmodule : instruction_format_decoder_tb
